// ==== src/bfg_pkg.sv ====
// Contract
// - Highpass pin high selects 600kHz AC coupling.
// - Pin low: corner from filter_programming bits 13:12.
// - Mode bits 1:0 set receive lowpass coarse corner.
// - Filter bits 2:0 set receive lowpass fine trim.
// - Common-mode register bits 11:10 set output level.
// - Mode bits 9:8 choose strength monitor source.
// - Strength source drives only in receive mode.
// - Bit 10 set: monitor on; clear: needs pin.
// - Transmit enabled when mode pin and shutdown high.
// - Same bits 1:0 set transmit lowpass coarse corner.
// - Filter bits 5:3 set transmit fine trim.
// - Gain source bit 10 picks pins or register.
// - Gain code maps to half-dB attenuation steps above the knee, 1 dB per code pair below.
// - Receive enabled when mode pin low, shutdown high.
package bfg_pkg;

  // Serial word: 14 data bits then 4 address bits, most significant first.
  localparam int DATA_W = 14;
  localparam int ADDR_W = 4;
  localparam int WORD_W = DATA_W + ADDR_W;
  localparam logic [4:0] WORD_BITS = 5'h12;

  // Register addresses.
  localparam logic [3:0] ADDR_FILTER_PROG = 4'h7;
  localparam logic [3:0] ADDR_MODE_MON = 4'h8;
  localparam logic [3:0] ADDR_TX_GAIN_SRC = 4'h9;
  localparam logic [3:0] ADDR_TX_GAIN = 4'hC;
  localparam logic [3:0] ADDR_RX_CM = 4'hF;

  localparam logic [13:0] REG_RESET = 14'h0000;

  // Field positions.
  localparam int HP_CORNER_LSB = 12;
  localparam int RX_FINE_LSB = 0;
  localparam int TX_FINE_LSB = 3;
  localparam int COARSE_LSB = 0;
  localparam int MON_SRC_LSB = 8;
  localparam int MON_GATE_BIT = 10;
  localparam int GAIN_SRC_BIT = 10;
  localparam int GAIN_LSB = 0;
  localparam int CM_LSB = 10;

  // Highpass corner encoding on the output.
  localparam logic [1:0] HPC_100HZ = 2'h0;
  localparam logic [1:0] HPC_4KHZ = 2'h1;
  localparam logic [1:0] HPC_30KHZ = 2'h2;
  localparam logic [1:0] HPC_600KHZ = 2'h3;

  // Strength monitor sources.
  localparam logic [1:0] MON_STRENGTH_MONITOR_OUT = 2'h0;
  localparam logic [1:0] MON_TEMP = 2'h1;
  localparam logic [1:0] MON_PDET = 2'h2;

  // Fine trim codes above these are unused.
  localparam logic [2:0] RX_FINE_MAX = 3'h4;
  localparam logic [2:0] TX_FINE_MAX = 3'h5;

  // Gain code mapping.
  localparam logic [5:0] GAIN_MAX_CODE = 6'h3F;
  localparam logic [5:0] GAIN_KNEE_CODE = 6'h2F;
  localparam logic [6:0] KNEE_ATTEN_HALF_DB = 7'h10;

endpackage

// ==== src/bfg_top.sv ====
`timescale 1ns/1ps
module bfg_top (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // Serial register port.
  input wire logic SER_CS_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  // Mode and control pins.
  input wire logic HIGHPASS_SELECT_PIN,
  input wire logic RECEIVE_TRANSMIT_PIN,
  input wire logic SHUTDOWN_PIN_N,
  input wire logic [5:0] PARALLEL_GAIN_PINS,
  // Receive path controls.
  output logic RX_ENABLE,
  output logic HP_AC_COUPLE,
  output logic [1:0] HP_CORNER_SEL,
  output logic [1:0] RX_LPF_COARSE,
  output logic [2:0] RX_LPF_FINE,
  output logic RX_LPF_FINE_VALID,
  output logic [1:0] RX_CM_SEL,
  // Strength monitor controls.
  output logic [1:0] MON_SRC_SEL,
  output logic MON_ENABLE,
  // Transmit path controls.
  output logic TX_ENABLE,
  output logic [1:0] TX_LPF_COARSE,
  output logic [2:0] TX_LPF_FINE,
  output logic TX_LPF_FINE_VALID,
  output logic [5:0] TX_GAIN_CODE,
  output logic [6:0] TX_ATTEN_HALF_DB
);
  import bfg_pkg::*;

  // Attenuation below maximum, in half-dB units.
  function automatic logic [6:0] gain_atten(input logic [5:0] code);
    logic [5:0] below;
    logic [6:0] result;
    below = 6'h00;
    result = 7'h00;
    if (code > GAIN_KNEE_CODE) begin
      below = GAIN_MAX_CODE - code;
      result = {1'b0, below};
    end else begin
      below = GAIN_KNEE_CODE - code;
      result = KNEE_ATTEN_HALF_DB + {1'b0, below[5:1], 1'b0};
    end
    return result;
  endfunction

  // Serial shifter state.
  logic sclk_prev_reg, sclk_prev_next;
  logic cs_prev_reg, cs_prev_next;
  logic [WORD_W-1:0] shift_reg, shift_next;
  logic [4:0] count_reg, count_next;

  // Register bank.
  logic [DATA_W-1:0] filter_programming_reg, filter_programming_next;
  logic [DATA_W-1:0] mode_and_monitor_config_reg, mode_and_monitor_config_next;
  logic [DATA_W-1:0] tx_gain_source_config_reg, tx_gain_source_config_next;
  logic [DATA_W-1:0] tx_gain_setting_reg, tx_gain_setting_next;
  logic [DATA_W-1:0] rx_output_common_mode_reg, rx_output_common_mode_next;

  // Serial port: bits shift on SER_CLK rising while the select is low; the
  // word commits on the select's rising edge only if exactly 18 bits came in,
  // so a truncated frame never corrupts a register.
  always_comb begin
    sclk_prev_next = SER_CLK;
    cs_prev_next = SER_CS_N;
    shift_next = shift_reg;
    count_next = count_reg;
    if (SER_CS_N) begin
      count_next = 5'h00;
    end else if (SER_CLK && !sclk_prev_reg) begin
      shift_next = {shift_reg[WORD_W-2:0], SER_DATA};
      if (count_reg != 5'h1F) begin
        count_next = count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      shift_reg <= '0;
      count_reg <= 5'h00;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      cs_prev_reg <= cs_prev_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  logic commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  assign commit = SER_CS_N && !cs_prev_reg && (count_reg == WORD_BITS);
  assign wr_data = shift_reg[WORD_W-1:ADDR_W];
  assign wr_addr = shift_reg[ADDR_W-1:0];

  // Addresses outside this bank are ignored here; a commit to one writes no register.
  always_comb begin
    filter_programming_next = filter_programming_reg;
    mode_and_monitor_config_next = mode_and_monitor_config_reg;
    tx_gain_source_config_next = tx_gain_source_config_reg;
    tx_gain_setting_next = tx_gain_setting_reg;
    rx_output_common_mode_next = rx_output_common_mode_reg;
    if (commit) begin
      if (wr_addr == ADDR_FILTER_PROG) begin
        filter_programming_next = wr_data;
      end else if (wr_addr == ADDR_MODE_MON) begin
        mode_and_monitor_config_next = wr_data;
      end else if (wr_addr == ADDR_TX_GAIN_SRC) begin
        tx_gain_source_config_next = wr_data;
      end else if (wr_addr == ADDR_TX_GAIN) begin
        tx_gain_setting_next = wr_data;
      end else if (wr_addr == ADDR_RX_CM) begin
        rx_output_common_mode_next = wr_data;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      filter_programming_reg <= REG_RESET;
      mode_and_monitor_config_reg <= REG_RESET;
      tx_gain_source_config_reg <= REG_RESET;
      tx_gain_setting_reg <= REG_RESET;
      rx_output_common_mode_reg <= REG_RESET;
    end else begin
      filter_programming_reg <= filter_programming_next;
      mode_and_monitor_config_reg <= mode_and_monitor_config_next;
      tx_gain_source_config_reg <= tx_gain_source_config_next;
      tx_gain_setting_reg <= tx_gain_setting_next;
      rx_output_common_mode_reg <= rx_output_common_mode_next;
    end
  end

  // Fine trim codes above the top table entry have no defined corner.
  function automatic logic fine_ok(input logic [2:0] code, input logic [2:0] top);
    return code <= top;
  endfunction

  // Decoded controls. Each output has its own flip-flop, so a pin reaches its
  // output one clock late; that is far quicker than the analog blocks settle.
  logic rx_en_reg;
  logic rx_en_next;
  logic ac_reg;
  logic ac_next;
  logic [1:0] hpc_reg;
  logic [1:0] hpc_next;
  logic [1:0] rx_coarse_reg;
  logic [1:0] rx_coarse_next;
  logic [2:0] rx_fine_reg;
  logic [2:0] rx_fine_next;
  logic rx_fine_ok_reg;
  logic rx_fine_ok_next;
  logic [1:0] cm_reg;
  logic [1:0] cm_next;
  logic [1:0] mon_src_reg;
  logic [1:0] mon_src_next;
  logic mon_en_reg;
  logic mon_en_next;
  logic tx_en_reg;
  logic tx_en_next;
  logic [1:0] tx_coarse_reg;
  logic [1:0] tx_coarse_next;
  logic [2:0] tx_fine_reg;
  logic [2:0] tx_fine_next;
  logic tx_fine_ok_reg;
  logic tx_fine_ok_next;
  logic [5:0] gain_reg;
  logic [5:0] gain_next;
  logic [6:0] atten_reg;
  logic [6:0] atten_next;

  // Receive path: enable, highpass coupling, lowpass corners and common mode.
  always_comb begin
    logic [1:0] hp_field;
    hp_field = filter_programming_reg[HP_CORNER_LSB +: 2];
    rx_en_next = !RECEIVE_TRANSMIT_PIN && SHUTDOWN_PIN_N;
    ac_next = HIGHPASS_SELECT_PIN;
    if (HIGHPASS_SELECT_PIN) begin
      hpc_next = HPC_600KHZ;
    end else if (hp_field[0]) begin
      hpc_next = HPC_4KHZ;
    end else if (hp_field[1]) begin
      hpc_next = HPC_30KHZ;
    end else begin
      hpc_next = HPC_100HZ;
    end
    rx_coarse_next = mode_and_monitor_config_reg[COARSE_LSB +: 2];
    rx_fine_next = filter_programming_reg[RX_FINE_LSB +: 3];
    rx_fine_ok_next = fine_ok(rx_fine_next, RX_FINE_MAX);
    cm_next = rx_output_common_mode_reg[CM_LSB +: 2];
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_en_reg <= 1'b0;
      ac_reg <= 1'b0;
      hpc_reg <= HPC_100HZ;
      rx_coarse_reg <= 2'h0;
      rx_fine_reg <= 3'h0;
      rx_fine_ok_reg <= 1'b0;
      cm_reg <= 2'h0;
    end else begin
      rx_en_reg <= rx_en_next;
      ac_reg <= ac_next;
      hpc_reg <= hpc_next;
      rx_coarse_reg <= rx_coarse_next;
      rx_fine_reg <= rx_fine_next;
      rx_fine_ok_reg <= rx_fine_ok_next;
      cm_reg <= cm_next;
    end
  end

  // Strength monitor: source select and output gating.
  always_comb begin
    logic rx_mode;
    rx_mode = !RECEIVE_TRANSMIT_PIN && SHUTDOWN_PIN_N;
    mon_src_next = mode_and_monitor_config_reg[MON_SRC_LSB +: 2];
    // The gate follows the truth table: bit set forces the output on. The
    // prose reads the other way round; the table was judged the safer guide.
    mon_en_next = mode_and_monitor_config_reg[MON_GATE_BIT] || HIGHPASS_SELECT_PIN;
    if (mon_src_next == MON_STRENGTH_MONITOR_OUT) begin
      mon_en_next = mon_en_next && rx_mode;
    end else if (mon_src_next != MON_TEMP && mon_src_next != MON_PDET) begin
      mon_en_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mon_src_reg <= MON_STRENGTH_MONITOR_OUT;
      mon_en_reg <= 1'b0;
    end else begin
      mon_src_reg <= mon_src_next;
      mon_en_reg <= mon_en_next;
    end
  end

  // Transmit path: enable and lowpass corners.
  always_comb begin
    tx_en_next = RECEIVE_TRANSMIT_PIN && SHUTDOWN_PIN_N;
    tx_coarse_next = mode_and_monitor_config_reg[COARSE_LSB +: 2];
    tx_fine_next = filter_programming_reg[TX_FINE_LSB +: 3];
    tx_fine_ok_next = fine_ok(tx_fine_next, TX_FINE_MAX);
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_en_reg <= 1'b0;
      tx_coarse_reg <= 2'h0;
      tx_fine_reg <= 3'h0;
      tx_fine_ok_reg <= 1'b0;
    end else begin
      tx_en_reg <= tx_en_next;
      tx_coarse_reg <= tx_coarse_next;
      tx_fine_reg <= tx_fine_next;
      tx_fine_ok_reg <= tx_fine_ok_next;
    end
  end

  // Transmit gain. Pin codes pass through the same flip-flop as register
  // codes, so switching the source never shows a half-updated code.
  always_comb begin
    if (tx_gain_source_config_reg[GAIN_SRC_BIT]) begin
      gain_next = tx_gain_setting_reg[GAIN_LSB +: 6];
    end else begin
      gain_next = PARALLEL_GAIN_PINS;
    end
    atten_next = gain_atten(gain_next);
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      gain_reg <= 6'h00;
      atten_reg <= 7'h00;
    end else begin
      gain_reg <= gain_next;
      atten_reg <= atten_next;
    end
  end

  // Output ports.
  assign RX_ENABLE = rx_en_reg;
  assign HP_AC_COUPLE = ac_reg;
  assign HP_CORNER_SEL = hpc_reg;
  assign RX_LPF_COARSE = rx_coarse_reg;
  assign RX_LPF_FINE = rx_fine_reg;
  assign RX_LPF_FINE_VALID = rx_fine_ok_reg;
  assign RX_CM_SEL = cm_reg;
  assign MON_SRC_SEL = mon_src_reg;
  assign MON_ENABLE = mon_en_reg;
  assign TX_ENABLE = tx_en_reg;
  assign TX_LPF_COARSE = tx_coarse_reg;
  assign TX_LPF_FINE = tx_fine_reg;
  assign TX_LPF_FINE_VALID = tx_fine_ok_reg;
  assign TX_GAIN_CODE = gain_reg;
  assign TX_ATTEN_HALF_DB = atten_reg;

endmodule

// ==== tb/bfg_chk.sv ====
`timescale 1ns/1ps
module bfg_chk import bfg_pkg::*; (
  // Clock, reset and pins.
  input wire logic CORE_CLK, RSTN,
  input wire logic HIGHPASS_SELECT_PIN, RECEIVE_TRANSMIT_PIN, SHUTDOWN_PIN_N,
  // Decoded controls.
  input wire logic RX_ENABLE, HP_AC_COUPLE, RX_LPF_FINE_VALID, TX_LPF_FINE_VALID,
  input wire logic MON_ENABLE, TX_ENABLE,
  input wire logic [1:0] HP_CORNER_SEL, RX_LPF_COARSE, TX_LPF_COARSE, MON_SRC_SEL,
  input wire logic [2:0] RX_LPF_FINE, TX_LPF_FINE,
  input wire logic [5:0] TX_GAIN_CODE,
  input wire logic [6:0] TX_ATTEN_HALF_DB
);
  logic [6:0] atten_exp;
  // Pairs of codes share one 1 dB step below the half-dB knee.
  always_comb begin
    atten_exp = (TX_GAIN_CODE >= 6'h30) ? 7'(6'h3F - TX_GAIN_CODE) :
                7'h10 + {(6'h2F - TX_GAIN_CODE) >> 1, 1'b0};
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_hp_high;
    $past(RSTN) && HIGHPASS_SELECT_PIN;
  endsequence
  hp_ac_a: assert property (s_hp_high |=> HP_AC_COUPLE && HP_CORNER_SEL == HPC_600KHZ)
    else $error("highpass pin did not force AC coupling");
  rx_en_a: assert property ($past(RSTN) |->
    RX_ENABLE == $past(!RECEIVE_TRANSMIT_PIN && SHUTDOWN_PIN_N)) else $error("rx enable wrong");
  tx_en_a: assert property ($past(RSTN) |->
    TX_ENABLE == $past(RECEIVE_TRANSMIT_PIN && SHUTDOWN_PIN_N)) else $error("tx enable wrong");
  coarse_tie_a: assert property ($past(RSTN) |-> RX_LPF_COARSE == TX_LPF_COARSE)
    else $error("coarse corners differ");
  rx_fine_a: assert property ($past(RSTN) |-> RX_LPF_FINE_VALID == (RX_LPF_FINE <= 3'h4))
    else $error("rx fine valid wrong");
  tx_fine_a: assert property ($past(RSTN) |-> TX_LPF_FINE_VALID == (TX_LPF_FINE <= 3'h5))
    else $error("tx fine valid wrong");
  atten_map_a: assert property ($past(RSTN) |-> TX_ATTEN_HALF_DB == atten_exp)
    else $error("attenuation mapping wrong");
  mon_gate_a: assert property (MON_ENABLE |-> MON_SRC_SEL != 2'h3 &&
    (MON_SRC_SEL != MON_STRENGTH_MONITOR_OUT || RX_ENABLE)) else $error("monitor enabled wrongly");
endmodule
bind bfg_top bfg_chk u_chk (.*);

// ==== tb/bfg_ctl_model.sv ====
`timescale 1ns/1ps
module bfg_ctl_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic sdata
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // The bit clock stands low outside frames; data flips when released.
  task automatic send(input logic [17:0] w, input int n);
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) sdata <= w[17 - i];
      repeat (2) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    sdata <= ~sdata;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ==== tb/bfg_top_tb_top.sv ====
`timescale 1ns/1ps
module bfg_top_tb_top;
  import bfg_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, hp = 1'b0, rt = 1'b0, sd = 1'b0;
  logic [5:0] gp = 6'h00, gc;
  logic cs_n, sck, sdi, rx_en, hp_ac, fine_v, tfine_v, mon_en, tx_en;
  logic [1:0] hpc, rxc, cm, msrc, txc;
  logic [2:0] rxf, txf;
  logic [6:0] att;
  int fail_count = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  bfg_ctl_model u_ctl (.clk(clk), .cs_n(cs_n), .sclk(sck), .sdata(sdi));
  bfg_top u_dut (.CORE_CLK(clk), .RSTN(rstn), .SER_CS_N(cs_n), .SER_CLK(sck), .SER_DATA(sdi),
    .HIGHPASS_SELECT_PIN(hp), .RECEIVE_TRANSMIT_PIN(rt), .SHUTDOWN_PIN_N(sd),
    .PARALLEL_GAIN_PINS(gp), .RX_ENABLE(rx_en), .HP_AC_COUPLE(hp_ac), .HP_CORNER_SEL(hpc),
    .RX_LPF_COARSE(rxc), .RX_LPF_FINE(rxf), .RX_LPF_FINE_VALID(fine_v), .RX_CM_SEL(cm),
    .MON_SRC_SEL(msrc), .MON_ENABLE(mon_en), .TX_ENABLE(tx_en), .TX_LPF_COARSE(txc),
    .TX_LPF_FINE(txf), .TX_LPF_FINE_VALID(tfine_v), .TX_GAIN_CODE(gc), .TX_ATTEN_HALF_DB(att));
  task automatic chk(input string n, input logic [6:0] s, input logic [6:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Outputs are registered, so pin changes are looked at two edges later.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pins(input logic h, input logic r, input logic s);
    @(posedge clk);
    hp <= h;
    rt <= r;
    sd <= s;
    settle;
  endtask
  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    u_ctl.send({d, a}, 18);
    #1;
  endtask
  task automatic t_enables;
    for (int i = 0; i < 4; i++) begin
      pins(1'b0, i[0], i[1]);
      chk("rx_en", rx_en, !i[0] && i[1]);
      chk("tx_en", tx_en, i[0] && i[1]);
    end
  endtask
  task automatic t_highpass;
    logic [1:0] e [4] = '{HPC_100HZ, HPC_4KHZ, HPC_30KHZ, HPC_4KHZ};
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_FILTER_PROG, 14'(c) << 12);
      pins(1'b0, 1'b0, 1'b1);
      chk("hpc", hpc, e[c]);
      chk("hp_ac", hp_ac, 7'h00);
      pins(1'b1, 1'b0, 1'b1);
      chk("hpc", hpc, HPC_600KHZ);
      chk("hp_ac", hp_ac, 7'h01);
    end
  endtask
  task automatic t_filters;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_FILTER_PROG, 14'({c[2:0], c[2:0]}));
      wr(ADDR_MODE_MON, 14'(c[1:0]));
      wr(ADDR_RX_CM, 14'(c[1:0]) << 10);
      chk("rxf", rxf, c[2:0]);
      chk("fine_v", fine_v, c < 5);
      chk("txf", txf, c[2:0]);
      chk("tfine_v", tfine_v, c < 6);
      chk("rxc", rxc, c[1:0]);
      chk("txc", txc, c[1:0]);
      chk("cm", cm, c[1:0]);
    end
  endtask
  task automatic t_monitor;
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE_MON, 14'(m[2:0]) << 8);
      for (int p = 0; p < 4; p++) begin
        pins(p[0], p[1], 1'b1);
        chk("msrc", msrc, m[1:0]);
        chk("mon_en", mon_en, m[1:0] != 2'h3 && (m[2] || p[0]) && (m[1:0] != 2'h0 || !p[1]));
      end
    end
  endtask
  task automatic t_gain;
    logic [5:0] v [6] = '{6'h00, 6'h01, 6'h2E, 6'h2F, 6'h30, 6'h3F};
    logic [6:0] a [6] = '{7'h3E, 7'h3E, 7'h10, 7'h10, 7'h0F, 7'h00};
    wr(ADDR_TX_GAIN_SRC, 14'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) gp <= v[i];
      settle;
      chk("gc", gc, v[i]);
      chk("att", att, a[i]);
    end
    wr(ADDR_TX_GAIN_SRC, 14'h0400);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) gp <= ~v[i];
      wr(ADDR_TX_GAIN, 14'(v[i]));
      chk("gc", gc, v[i]);
      chk("att", att, a[i]);
    end
  endtask
  // A short frame and an unmapped address must both leave registers alone.
  task automatic t_refuse;
    wr(ADDR_RX_CM, 14'h0400);
    u_ctl.send({14'h0C00, ADDR_RX_CM}, 17);
    u_ctl.send({14'h0800, 4'h3}, 18);
    #1;
    chk("cm", cm, 7'h01);
  endtask
  task automatic t_reset;
    @(posedge clk) rstn <= 1'b0;
    #1;
    chk("tx_en", tx_en, 7'h00);
    @(posedge clk) rstn <= 1'b1;
    settle;
    chk("cm", cm, 7'h00);
    chk("fine_v", fine_v, 7'h01);
    chk("gc", gc, gp);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_enables;
    t_highpass;
    t_filters;
    t_monitor;
    t_gain;
    t_refuse;
    t_reset;
    end_sim;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule
